// ### common/dac_fe_pkg.sv
`default_nettype none
package dac_fe_pkg;
    // sample bus
    localparam int DATA_W = 14;
    // serial port frame: 8 instruction bits then 16 data bits
    localparam logic [4:0] INSTR_LAST = 5'h07;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam int READ_FLAG_BIT = 7;
    localparam int FOUR_WIRE_BIT = 9;
    localparam int REVERSE_BIT = 1;
    localparam logic [6:0] ADDR_CFG0 = 7'h00;
    localparam logic [6:0] ADDR_STATUS = 7'h01;
    localparam logic [15:0] CFG0_RESET = 16'h0000;
    // cycle counts
    localparam logic [3:0] SCLK_HALF_LAST = 4'h7;
    localparam logic [6:0] ALARM_LIMIT = 7'h40;
    localparam logic [2:0] PULSE_HOLD = 3'h4;
    localparam logic [3:0] RST_PULSE = 4'h8;
    // controller register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SAMPLE = 8'h04;
    localparam logic [7:0] REG_SCMD = 8'h08;
    localparam logic [7:0] REG_SRDATA = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam logic [7:0] REG_DEVSTAT = 8'h18;
    // control register fields
    localparam int CTRL_GATE = 0;
    localparam int CTRL_SLEEP = 1;
    localparam int CTRL_ALIGN = 2;
    localparam int CTRL_SYNC = 3;
    localparam int CTRL_FOUR_WIRE = 4;
    localparam int CTRL_PINS = 5;
    localparam int CTRL_HOLD = 6;
    localparam logic [31:0] CTRL_RESET = 32'h00000020;
    localparam int SAMPLE_B_LSB = 16;
    localparam int SCMD_BUSY_BIT = 31;
    // interrupt bits
    localparam int IRQ_SPI_DONE = 0;
    localparam int IRQ_ALARM = 1;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### common/dac_pins_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dac_pins_if;
    // controller side drives
    logic        pinsOe;
    logic        rstDrv;
    logic        selDrv;
    logic        sclkDrv;
    logic        sleepDrv;
    logic        gateDrv;
    logic        sdioH;
    logic        sdioHOe;
    logic        ddr_clock_pos;
    logic        ddr_clock_neg;
    logic        converter_sample_clock;
    logic [13:0] data;
    logic        divider_align_pos;
    logic        divider_align_neg;
    logic        fifo_sync_pos;
    logic        fifo_sync_neg;
    // device side drives
    logic        sdioD;
    logic        sdioDOe;
    logic        readOutD;
    logic        readOutDOe;
    logic        alarm;
    // wire levels with pull defaults when undriven
    logic        serial_port_rst_n;
    logic        serial_select_n;
    logic        serialClk;
    logic        serialData;
    logic        serial_read_out;
    logic        sleep;
    logic        transmit_gate;
    assign serial_port_rst_n = pinsOe ? rstDrv : 1'b1;
    assign serial_select_n = pinsOe ? selDrv : 1'b1;
    assign serialClk = pinsOe & sclkDrv;
    assign sleep = pinsOe & sleepDrv;
    assign transmit_gate = pinsOe & gateDrv;
    assign serialData = sdioDOe ? sdioD : (sdioHOe & sdioH);
    assign serial_read_out = readOutDOe & readOutD;
    modport device (
        input  serial_port_rst_n, serial_select_n, serialClk, serialData, sleep, transmit_gate,
        input  ddr_clock_pos, ddr_clock_neg, converter_sample_clock, data,
        input  divider_align_pos, divider_align_neg, fifo_sync_pos, fifo_sync_neg,
        output sdioD, sdioDOe, readOutD, readOutDOe, alarm
    );
    modport host (
        output pinsOe, rstDrv, selDrv, sclkDrv, sleepDrv, gateDrv, sdioH, sdioHOe,
        output ddr_clock_pos, ddr_clock_neg, converter_sample_clock, data,
        output divider_align_pos, divider_align_neg, fifo_sync_pos, fifo_sync_neg,
        input  serialData, serial_read_out, alarm
    );
endinterface
`default_nettype wire

// ### hdl/dual_dac_ddr_input_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module dual_dac_ddr_input_front_end (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // pins toward the data source
    dac_pins_if.device       pins,
    // converter side
    output var  logic [13:0] ampA,
    output var  logic [13:0] ampB,
    output var  logic        pairValid,
    output var  logic        syncEvent,
    output var  logic        alignEvent,
    output var  logic [1:0]  dividerPhase,
    output var  logic        asleep
);
    typedef struct packed {
        logic [1:0]  ddrS;
        logic        ddrPrev;
        logic [13:0] dat1;
        logic [13:0] dat2;
        logic [1:0]  gateS;
        logic [1:0]  sleepS;
        logic [1:0]  syncS;
        logic [1:0]  alignS;
        logic [1:0]  convS;
        logic        convPrev;
        logic [1:0]  sclkS;
        logic        sclkPrev;
        logic [1:0]  selS;
        logic [1:0]  sdiS;
        logic        haveA;
        logic [13:0] wordA;
        logic [13:0] ampA;
        logic [13:0] ampB;
        logic        pairValid;
        logic        syncEvent;
        logic        alignEvent;
        logic [1:0]  divPhase;
        logic [6:0]  idleCnt;
        logic        alarm;
        logic [15:0] cfg;
        logic [4:0]  bitCnt;
        logic [7:0]  instr;
        logic [15:0] shift;
        logic        reading;
        logic        sdoBit;
        logic        sdioOe;
        logic        readOutOe;
    } dev_state_t;

    dev_state_t q;
    dev_state_t d;
    logic [13:0] revWord;
    logic [13:0] word;
    logic        active;
    logic        ddrEdge;
    logic        convRise;
    logic        sRise;
    logic        sFall;
    logic        fourWire;
    logic [6:0]  rdAddr;
    logic [15:0] rdVal;
    logic        rstAll;

    // bit-reversed view of the captured word
    for (genvar i = 0; i < dac_fe_pkg::DATA_W; i++) begin : g_rev
        assign revWord[i] = q.dat2[dac_fe_pkg::DATA_W - 1 - i];
    end

    // either reset initialises everything; the serial reset pin acts without the clock
    assign rstAll = rst_n & pins.serial_port_rst_n;

    // next state
    always_comb begin
        d = q;
        // two-flop synchronisers for every pin used except the serial reset
        d.ddrS = {q.ddrS[0], pins.ddr_clock_pos};
        d.dat1 = pins.data;
        d.dat2 = q.dat1;
        d.gateS = {q.gateS[0], pins.transmit_gate};
        d.sleepS = {q.sleepS[0], pins.sleep};
        d.syncS = {q.syncS[0], pins.fifo_sync_pos & ~pins.fifo_sync_neg};
        d.alignS = {q.alignS[0], pins.divider_align_pos & ~pins.divider_align_neg};
        d.convS = {q.convS[0], pins.converter_sample_clock};
        d.sclkS = {q.sclkS[0], pins.serialClk};
        d.selS = {q.selS[0], pins.serial_select_n};
        d.sdiS = {q.sdiS[0], pins.serialData};
        d.ddrPrev = q.ddrS[1];
        d.convPrev = q.convS[1];
        d.sclkPrev = q.sclkS[1];

        ddrEdge = q.ddrS[1] ^ q.ddrPrev;
        word = q.cfg[dac_fe_pkg::REVERSE_BIT] ? revWord : q.dat2;
        active = q.gateS[1] & ~q.sleepS[1];
        d.pairValid = 1'b0;
        d.syncEvent = 1'b0;
        d.alignEvent = 1'b0;

        // capture path: rise is channel A, fall completes the pair with B
        if (!active) begin
            d.wordA = '0;
            d.haveA = 1'b0;
            d.ampA = '1;
            d.ampB = '1;
        end else if (ddrEdge && q.ddrS[1]) begin
            if (q.syncS[1]) begin
                d.haveA = 1'b0;
                d.syncEvent = 1'b1;
            end else begin
                d.wordA = word;
                d.haveA = 1'b1;
            end
        end else if (ddrEdge && q.haveA) begin
            d.ampA = ~q.wordA;
            d.ampB = ~word;
            d.pairValid = 1'b1;
            d.haveA = 1'b0;
        end

        // alarm when the data clock stops while transmitting
        if (ddrEdge || !active) begin
            d.idleCnt = '0;
        end else if (q.idleCnt != dac_fe_pkg::ALARM_LIMIT) begin
            d.idleCnt = q.idleCnt + 7'h01;
        end
        d.alarm = (d.idleCnt == dac_fe_pkg::ALARM_LIMIT);

        // divider, cleared by alignment taken at converter clock rise
        convRise = q.convS[1] & ~q.convPrev;
        if (convRise) begin
            if (q.alignS[1]) begin
                d.divPhase = '0;
                d.alignEvent = 1'b1;
            end else begin
                d.divPhase = q.divPhase + 2'h1;
            end
        end

        // serial port: sample on clock rise, drive read data on fall
        sRise = q.sclkS[1] & ~q.sclkPrev;
        sFall = ~q.sclkS[1] & q.sclkPrev;
        fourWire = q.cfg[dac_fe_pkg::FOUR_WIRE_BIT];
        rdAddr = {q.instr[5:0], q.sdiS[1]};
        unique case (rdAddr)
            dac_fe_pkg::ADDR_CFG0: rdVal = q.cfg;
            dac_fe_pkg::ADDR_STATUS: rdVal = {13'h0000, q.alarm, q.sleepS[1], q.gateS[1]};
            default: rdVal = 16'h0000;
        endcase
        if (q.selS[1]) begin
            d.bitCnt = '0;
            d.reading = 1'b0;
            d.sdioOe = 1'b0;
            d.readOutOe = 1'b0;
        end else begin
            if (sRise && q.bitCnt <= dac_fe_pkg::FRAME_LAST) begin
                d.bitCnt = q.bitCnt + 5'h01;
                if (q.bitCnt <= dac_fe_pkg::INSTR_LAST) begin
                    d.instr = {q.instr[6:0], q.sdiS[1]};
                end else if (!q.reading) begin
                    d.shift = {q.shift[14:0], q.sdiS[1]};
                end
                if (q.bitCnt == dac_fe_pkg::INSTR_LAST && q.instr[dac_fe_pkg::READ_FLAG_BIT - 1]) begin
                    d.reading = 1'b1;
                    d.shift = rdVal;
                end
                if (q.bitCnt == dac_fe_pkg::FRAME_LAST && !q.reading
                    && q.instr[6:0] == dac_fe_pkg::ADDR_CFG0) begin
                    d.cfg = {q.shift[14:0], q.sdiS[1]};
                end
            end
            if (sFall && q.reading) begin
                d.sdoBit = q.shift[15];
                d.shift = {q.shift[14:0], 1'b0};
                d.sdioOe = ~fourWire;
                d.readOutOe = fourWire;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstAll) begin
        if (!rstAll) begin
            q <= '0;
            q.ampA <= '1;
            q.ampB <= '1;
            q.selS <= 2'h3;
            q.cfg <= dac_fe_pkg::CFG0_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign pins.sdioD = q.sdoBit;
    assign pins.sdioDOe = q.sdioOe;
    assign pins.readOutD = q.sdoBit;
    assign pins.readOutDOe = q.readOutOe;
    assign pins.alarm = q.alarm;
    assign ampA = q.ampA;
    assign ampB = q.ampB;
    assign pairValid = q.pairValid;
    assign syncEvent = q.syncEvent;
    assign alignEvent = q.alignEvent;
    assign dividerPhase = q.divPhase;
    assign asleep = q.sleepS[1];
endmodule
`default_nettype wire

// ### hdl/ddr_source_controller.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_source_controller (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // axi4-lite slave
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    output var  logic        irq,
    // device pins
    dac_pins_if.host         pins
);
    typedef enum logic [1:0] {SER_IDLE, SER_LOW, SER_HIGH} ser_state_t;
    typedef struct packed {
        logic        awReady;
        logic        wReady;
        logic        arReady;
        logic [7:0]  awAddr;
        logic [31:0] wData;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [31:0] sample;
        logic [1:0]  mask;
        logic [1:0]  stat;
        logic        irq;
        logic [1:0]  phase;
        logic        ddrClk;
        logic        convClk;
        logic [13:0] data;
        logic [2:0]  alignCnt;
        logic [2:0]  syncCnt;
        logic [3:0]  rstCnt;
        ser_state_t  ser;
        logic [3:0]  hcnt;
        logic [4:0]  bitIdx;
        logic        isRead;
        logic [23:0] cmd;
        logic [15:0] rdShift;
        logic [15:0] rdData;
        logic        sclk;
        logic        selN;
        logic        sdoOe;
        logic [1:0]  rdS;
        logic [1:0]  alarmS;
        logic        alarmPrev;
    } host_state_t;

    host_state_t q;
    host_state_t d;
    logic [31:0] wmask;
    logic        fourWire;

    // next state
    always_comb begin
        d = q;
        fourWire = q.ctrl[dac_fe_pkg::CTRL_FOUR_WIRE];
        wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
        d.rdS = {q.rdS[0], fourWire ? pins.serial_read_out : pins.serialData};
        d.alarmS = {q.alarmS[0], pins.alarm};
        d.alarmPrev = q.alarmS[1];
        // address and data are taken independently, answered once both are in
        if (awvalid && q.awReady) begin
            d.awAddr = awaddr;
            d.awReady = 1'b0;
        end
        if (wvalid && q.wReady) begin
            d.wData = (q.wData & ~wmask) | (wdata & wmask);
            d.wReady = 1'b0;
        end
        if (!q.awReady && !q.wReady && !q.bvalid) begin
            d.bvalid = 1'b1;
            d.bresp = dac_fe_pkg::RESP_OKAY;
            unique case (q.awAddr)
                dac_fe_pkg::REG_CTRL: begin
                    d.ctrl = q.wData & 32'h00000073;
                    if (q.wData[dac_fe_pkg::CTRL_ALIGN]) d.alignCnt = dac_fe_pkg::PULSE_HOLD;
                    if (q.wData[dac_fe_pkg::CTRL_SYNC]) d.syncCnt = dac_fe_pkg::PULSE_HOLD;
                end
                dac_fe_pkg::REG_SAMPLE: d.sample = q.wData;
                dac_fe_pkg::REG_SCMD: begin
                    if (q.ser == SER_IDLE) begin
                        d.cmd = q.wData[23:0];
                        d.isRead = q.wData[16 + dac_fe_pkg::READ_FLAG_BIT];
                        d.sdoOe = 1'b1;
                        d.selN = 1'b0;
                        d.hcnt = '0;
                        d.bitIdx = '0;
                        d.ser = SER_LOW;
                    end
                end
                dac_fe_pkg::REG_IRQ_MASK: d.mask = q.wData[1:0];
                default: d.bresp = dac_fe_pkg::RESP_SLVERR;
            endcase
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
            d.awReady = 1'b1;
            d.wReady = 1'b1;
        end
        // reads; the status register clears on read
        if (arvalid && q.arReady) begin
            d.arReady = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = dac_fe_pkg::RESP_OKAY;
            d.rdata = '0;
            unique case (araddr)
                dac_fe_pkg::REG_CTRL: d.rdata = q.ctrl;
                dac_fe_pkg::REG_SAMPLE: d.rdata = q.sample;
                dac_fe_pkg::REG_SCMD: d.rdata[dac_fe_pkg::SCMD_BUSY_BIT] = (q.ser != SER_IDLE);
                dac_fe_pkg::REG_SRDATA: d.rdata[15:0] = q.rdData;
                dac_fe_pkg::REG_IRQ_STAT: begin
                    d.rdata[1:0] = q.stat;
                    d.stat = '0;
                end
                dac_fe_pkg::REG_IRQ_MASK: d.rdata[1:0] = q.mask;
                dac_fe_pkg::REG_DEVSTAT: d.rdata[0] = q.alarmS[1];
                default: d.rresp = dac_fe_pkg::RESP_SLVERR;
            endcase
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
            d.arReady = 1'b1;
        end
        // ddr stream: data changes midway between clock edges
        if (!q.ctrl[dac_fe_pkg::CTRL_HOLD]) d.phase = q.phase + 2'h1;
        unique case (q.phase)
            2'h0: d.ddrClk = 1'b1;
            2'h1: d.data = q.sample[dac_fe_pkg::SAMPLE_B_LSB +: dac_fe_pkg::DATA_W];
            2'h2: d.ddrClk = 1'b0;
            2'h3: d.data = q.sample[dac_fe_pkg::DATA_W - 1:0];
        endcase
        if (q.phase[0]) d.convClk = ~q.convClk;
        if (q.alignCnt != 3'h0) d.alignCnt = q.alignCnt - 3'h1;
        if (q.syncCnt != 3'h0) d.syncCnt = q.syncCnt - 3'h1;
        // serial reset held low for a while after power-up
        if (q.rstCnt != dac_fe_pkg::RST_PULSE) d.rstCnt = q.rstCnt + 4'h1;
        // serial master
        unique case (q.ser)
            SER_IDLE: d.sclk = 1'b0;
            SER_LOW: begin
                d.hcnt = q.hcnt + 4'h1;
                if (q.hcnt == dac_fe_pkg::SCLK_HALF_LAST) begin
                    d.hcnt = '0;
                    d.sclk = 1'b1;
                    d.ser = SER_HIGH;
                    if (q.isRead && q.bitIdx > dac_fe_pkg::INSTR_LAST) d.rdShift = {q.rdShift[14:0], q.rdS[1]};
                end
            end
            SER_HIGH: begin
                d.hcnt = q.hcnt + 4'h1;
                if (q.hcnt == dac_fe_pkg::SCLK_HALF_LAST) begin
                    d.hcnt = '0;
                    d.sclk = 1'b0;
                    if (q.bitIdx == dac_fe_pkg::FRAME_LAST) begin
                        d.selN = 1'b1;
                        d.sdoOe = 1'b0;
                        d.rdData = q.rdShift;
                        d.stat[dac_fe_pkg::IRQ_SPI_DONE] = 1'b1;
                        d.ser = SER_IDLE;
                    end else begin
                        d.bitIdx = q.bitIdx + 5'h01;
                        d.cmd = {q.cmd[22:0], 1'b0};
                        if (q.isRead && !fourWire && q.bitIdx >= dac_fe_pkg::INSTR_LAST) d.sdoOe = 1'b0;
                        d.ser = SER_LOW;
                    end
                end
            end
            default: d.ser = SER_IDLE;
        endcase
        // events set after any clear so a set in the same cycle wins
        if (q.alarmS[1] && !q.alarmPrev) d.stat[dac_fe_pkg::IRQ_ALARM] = 1'b1;
        d.irq = |(d.stat & d.mask);
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.awReady <= 1'b1;
            q.wReady <= 1'b1;
            q.arReady <= 1'b1;
            q.selN <= 1'b1;
            q.ser <= SER_IDLE;
            q.ctrl <= dac_fe_pkg::CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign awready = q.awReady;
    assign wready = q.wReady;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arReady;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = q.rdata;
    assign irq = q.irq;
    assign pins.pinsOe = q.ctrl[dac_fe_pkg::CTRL_PINS];
    assign pins.rstDrv = (q.rstCnt == dac_fe_pkg::RST_PULSE);
    assign pins.selDrv = q.selN;
    assign pins.sclkDrv = q.sclk;
    assign pins.sdioH = q.cmd[23];
    assign pins.sdioHOe = q.sdoOe;
    assign pins.gateDrv = q.ctrl[dac_fe_pkg::CTRL_GATE];
    assign pins.sleepDrv = q.ctrl[dac_fe_pkg::CTRL_SLEEP];
    assign pins.ddr_clock_pos = q.ddrClk;
    assign pins.ddr_clock_neg = ~q.ddrClk;
    assign pins.converter_sample_clock = q.convClk;
    assign pins.data = q.data;
    assign pins.divider_align_pos = (q.alignCnt != 3'h0);
    assign pins.divider_align_neg = (q.alignCnt == 3'h0);
    assign pins.fifo_sync_pos = (q.syncCnt != 3'h0);
    assign pins.fifo_sync_neg = (q.syncCnt == 3'h0);
endmodule
`default_nettype wire

// ### test/dac_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dac_link_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin levels seen on the link
    input wire logic serial_port_rst_n,
    input wire logic serial_select_n,
    input wire logic transmit_gate,
    input wire logic sleep,
    input wire logic ddr_clock_pos,
    input wire logic sdioDOe,
    input wire logic readOutDOe,
    input wire logic alarm
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // cycles spent gated on, awake, with no data clock edge
    logic [7:0] idleCnt_q;
    logic       prevClk_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idleCnt_q <= 8'h00;
            prevClk_q <= 1'b0;
        end else begin
            prevClk_q <= ddr_clock_pos;
            if (!serial_port_rst_n || !transmit_gate || sleep || ddr_clock_pos != prevClk_q)
                idleCnt_q <= 8'h00;
            else if (idleCnt_q != 8'hff)
                idleCnt_q <= idleCnt_q + 8'h01;
        end
    end
    a_sdio_idle_release: assert property (serial_select_n [*4] |-> !sdioDOe)
        else $error("data pin driven outside a frame");
    a_pins_not_both: assert property (!(sdioDOe && readOutDOe))
        else $error("both serial outputs driven");
    a_readout_idle: assert property (serial_select_n [*4] |-> !readOutDOe)
        else $error("read-out pin driven outside a frame");
    a_serial_reset_quiet: assert property (!serial_port_rst_n |-> !alarm && !sdioDOe && !readOutDOe)
        else $error("outputs active during serial reset");
    a_gate_low_quiet: assert property ((!transmit_gate) [*4] |-> !alarm)
        else $error("alarm while gate low");
    a_alarm_rise_idle: assert property ($rose(alarm) |-> $stable(ddr_clock_pos))
        else $error("alarm rose during clock activity");
    a_alarm_clears: assert property (alarm && $changed(ddr_clock_pos) |-> ##[1:6] !alarm)
        else $error("alarm held after data clock edge");
    a_alarm_on_loss: assert property (idleCnt_q == 8'd80 |-> alarm)
        else $error("alarm missing after clock loss");
    // main scenarios
    c_frame: cover property ($fell(serial_select_n));
    c_sdio: cover property ($rose(sdioDOe));
    c_readout: cover property ($rose(readOutDOe));
endmodule
`default_nettype wire

// ### test/dual_dac_ddr_input_front_end_test.sv
`timescale 1ns/1ps
`default_nettype none
module dual_dac_ddr_input_front_end_test;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
    logic pairValid, syncEvent, alignEvent, asleep;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, dividerPhase, lastResp;
    logic [13:0] ampA, ampB;
    int error_cnt, num_checks, n, k;
    typedef struct {logic [31:0] smp; logic [13:0] ea; logic [13:0] eb;} row_t;
    row_t rows[3] = '{'{32'h3fff0000, 14'h3fff, 14'h0000}, '{32'h0abc1234, 14'h2dcb, 14'h3543},
                      '{32'h00013fff, 14'h0000, 14'h3ffe}};
    dac_pins_if pinsBus ();
    ddr_source_controller ddr_source_controller_inst (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .irq, .pins(pinsBus));
    dual_dac_ddr_input_front_end dual_dac_ddr_input_front_end_inst (.clk, .rst_n, .pins(pinsBus), .ampA,
        .ampB, .pairValid, .syncEvent, .alignEvent, .dividerPhase, .asleep);
    dac_link_monitor dac_link_monitor_inst (.clk, .rst_n, .serial_port_rst_n(pinsBus.serial_port_rst_n),
        .serial_select_n(pinsBus.serial_select_n), .transmit_gate(pinsBus.transmit_gate),
        .sleep(pinsBus.sleep), .ddr_clock_pos(pinsBus.ddr_clock_pos), .sdioDOe(pinsBus.sdioDOe),
        .readOutDOe(pinsBus.readOutDOe), .alarm(pinsBus.alarm));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // bus write, address and data offered together
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        lastResp = bresp;
    endtask
    // bus read into rd
    task automatic axiRd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        lastResp = rresp;
    endtask
    // serial frame, then poll busy
    task automatic frame(input logic [31:0] cmd);
        axiWr(dac_fe_pkg::REG_SCMD, cmd);
        rd = 32'hffffffff;
        for (n = 0; n < 300 && rd[31]; n++) axiRd(dac_fe_pkg::REG_SCMD);
        chk("frame busy", 32'h0, rd[31]);
    endtask
    // count pairs over a span
    task automatic pairs(input int span);
        k = 0;
        for (n = 0; n < span && k < 3; n++) begin
            @(posedge clk);
            k += pairValid;
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // watchdog
    initial begin
        #3000000;
        error_cnt++;
        results();
    end
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (16) @(posedge clk);
        chk("ampA reset", 32'h3fff, ampA);
        axiRd(dac_fe_pkg::REG_CTRL);
        chk("ctrl reset", dac_fe_pkg::CTRL_RESET, rd);
        axiWr(dac_fe_pkg::REG_IRQ_MASK, 32'h1);
        axiWr(dac_fe_pkg::REG_CTRL, 32'h21);
        foreach (rows[i]) begin
            axiWr(dac_fe_pkg::REG_SAMPLE, rows[i].smp);
            pairs(80);
            chk("ampA", rows[i].ea, ampA);
            chk("ampB", rows[i].eb, ampB);
        end
        $display("test stream done");
        frame(32'h00000002);
        frame(32'h00800000);
        chk("irq raised", 32'h1, irq);
        axiRd(dac_fe_pkg::REG_SRDATA);
        chk("cfg three-wire", 32'h2, rd);
        axiRd(dac_fe_pkg::REG_IRQ_STAT);
        chk("irq status", 32'h1, rd);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, irq);
        axiWr(dac_fe_pkg::REG_SAMPLE, 32'h20000001);
        pairs(80);
        chk("ampA reversed", 32'h1fff, ampA);
        chk("ampB reversed", 32'h3ffe, ampB);
        frame(32'h0001ffff);
        frame(32'h00810000);
        axiRd(dac_fe_pkg::REG_SRDATA);
        chk("device status", 32'h1, rd);
        frame(32'h00000200);
        axiWr(dac_fe_pkg::REG_CTRL, 32'h31);
        frame(32'h00800000);
        axiRd(dac_fe_pkg::REG_SRDATA);
        chk("cfg four-wire", 32'h200, rd);
        $display("test serial done");
        axiRd(8'hfc);
        chk("unmapped read", dac_fe_pkg::RESP_SLVERR, lastResp);
        axiWr(8'hfc, 32'h0);
        chk("unmapped write", dac_fe_pkg::RESP_SLVERR, lastResp);
        axiWr(dac_fe_pkg::REG_CTRL, 32'h35);
        for (n = 0; n < 40 && alignEvent !== 1'b1; n++) @(posedge clk);
        chk("align", 32'h1, alignEvent);
        chk("divider", 32'h0, dividerPhase);
        axiWr(dac_fe_pkg::REG_CTRL, 32'h39);
        for (n = 0; n < 40 && syncEvent !== 1'b1; n++) @(posedge clk);
        chk("sync", 32'h1, syncEvent);
        axiWr(dac_fe_pkg::REG_CTRL, 32'h61);
        repeat (80) @(posedge clk);
        axiRd(dac_fe_pkg::REG_DEVSTAT);
        chk("alarm", 32'h1, rd);
        axiRd(dac_fe_pkg::REG_IRQ_STAT);
        chk("irq alarm", 32'h3, rd);
        axiWr(dac_fe_pkg::REG_CTRL, 32'h30);
        repeat (10) @(posedge clk);
        pairs(20);
        chk("pairs gate low", 32'h0, k);
        chk("ampA gate low", 32'h3fff, ampA);
        axiWr(dac_fe_pkg::REG_CTRL, 32'h33);
        repeat (10) @(posedge clk);
        chk("asleep", 32'h1, asleep);
        chk("ampB asleep", 32'h3fff, ampB);
        axiWr(dac_fe_pkg::REG_CTRL, 32'h03);
        pairs(20);
        chk("pairs released", 32'h0, k);
        chk("asleep released", 32'h0, asleep);
        $display("test pins done");
        results();
    end
endmodule
`default_nettype wire
